// ==== rtl/ctl_pkg.sv ====
// Constants, field layouts and carriers for the operand decode core.
// Assumes a single 50 MHz clock shared by all users of the package.
package ctl_pkg;

    // Timing
    localparam int CLK_PERIOD_NS  = 20;
    localparam int INSTR_CYCLE_NS = 250;
    localparam int PHASE_COUNT    = 5;
    localparam int PHASE_CYCLES   =
        (INSTR_CYCLE_NS / (PHASE_COUNT * CLK_PERIOD_NS)) < 1 ? 1 :
        (INSTR_CYCLE_NS / (PHASE_COUNT * CLK_PERIOD_NS));

    // Widths
    localparam int BYTE_WIDTH      = 8;
    localparam int PROG_ADDR_WIDTH = 13;
    localparam int SHORT_IMM_WIDTH = 5;
    localparam int REG_COUNT       = 16;

    // Operation codes
    localparam logic [2:0] OP_MOVE             = 3'h0;
    localparam logic [2:0] OP_ADD              = 3'h1;
    localparam logic [2:0] OP_AND              = 3'h2;
    localparam logic [2:0] OP_XOR              = 3'h3;
    localparam logic [2:0] OP_EXECUTE_INDIRECT = 3'h4;
    localparam logic [2:0] OP_BRANCH_NONZERO   = 3'h5;
    localparam logic [2:0] OP_LITERAL_TRANSMIT = 3'h6;
    localparam logic [2:0] OP_ABSOLUTE_JUMP    = 3'h7;

    // Selector values
    localparam logic [4:0] SEL_AUX                = 5'h00;
    localparam logic [4:0] SEL_LAST_WORKING       = 5'h06;
    localparam logic [4:0] SEL_LEFT_PORT_SELECT   = 5'h07;
    localparam logic [4:0] SEL_CARRY_FLAG         = 5'h08;
    localparam logic [4:0] SEL_R11                = 5'h09;
    localparam logic [4:0] SEL_RIGHT_PORT_SELECT  = 5'h0f;
    localparam logic [1:0] SEL_LEFT_FIELD         = 2'h2;
    localparam logic [1:0] SEL_RIGHT_FIELD        = 2'h3;

    // Rotate/length field
    localparam logic [2:0] RL_FULL_BYTE = 3'h0;
    localparam logic [3:0] LEN_FULL     = 4'h8;

    // Software register port
    localparam logic [7:0]  REG_CTRL          = 8'h00;
    localparam logic [7:0]  REG_STATUS        = 8'h04;
    localparam int          CTRL_RUN_BIT      = 0;
    localparam int          STATUS_CARRY_BIT  = 13;
    localparam logic [0:0]  CTRL_RUN_RESET    = 1'h0;

    typedef struct packed {
        logic [2:0] op;
        logic [4:0] src;
        logic [2:0] rl;
        logic [4:0] dst;
    } instr_t;

    typedef struct packed {
        logic       leftBankStrobe_n;
        logic       rightBankStrobe_n;
        logic       selectCommandStrobe;
        logic       writeStrobe;
        logic       drive_n;
        logic [7:0] data;
    } ivCtl_t;

    localparam ivCtl_t IV_IDLE = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00};

endpackage : ctl_pkg

// ==== rtl/operand_decode.sv ====
// Operand decode and datapath core with two interface vector banks.
// Assumes program storage and port bytes answer within one phase.
//
// Behaviour
// - Register source and destination: rotate/length is a right rotate.
// - Rotation happens on the bus, source kept, within one cycle.
// - Any I/O field operand: rotate/length gives the field length.
// - Length code 0 means eight bits, 1 to 7 mean themselves.
// - Execute, branch, transmit: register selector gives 8-bit literal.
// - Same three: I/O field selector gives 5-bit literal.
// - Jump target is a 13-bit address covering 8192 locations.
// - Register into I/O field: result merged, other bits kept.
// - I/O field into register: field zero-extended, full byte stored.
// - Bank select registers are write-only destinations, read as zero.
// - Carry register is source only, changed only by add.
// - Port byte must be selected before its field is used.
// - One left and one right byte stay selected at once.
// - Selection holds until its select register is written again.
// - Select addresses span 0 to 255 per bank.
// - Move copies and keeps source; bank to bank uses the field length.
// - Add stores 8-bit sum with auxiliary; carry into carry register.
// - And stores source and auxiliary conjunction.
// - Exclusive-or stores source xor auxiliary.
// - Source and auxiliary unchanged unless named as destination.
// - Execute replaces low 5 or 8 address bits with source plus literal.
// - After indirect execute, counter advances past the execute unless jump, taken branch or another execute.
// - Select write pulses command strobe, drives data, lowers bank strobe.
// - Selectors: 00-17 registers, 20-27 left field, 30-37 right field.
// - Op codes 0-7: move, add, and, xor, execute, branch, transmit, jump.
`timescale 1ns/1ns
module operand_decode
    import ctl_pkg::*;
#(
    parameter int AW = PROG_ADDR_WIDTH
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // Program storage
    output logic [AW-1:0]      progAddr,
    input  wire logic [15:0]   instr,
    // Interface vector bus
    output ivCtl_t             ivCtl,
    input  wire logic [7:0]    ivIn,
    // Software register port
    input  wire logic [7:0]    regAddr,
    input  wire logic [31:0]   regWdata,
    input  wire logic          regWr,
    input  wire logic          regRd,
    output logic [31:0]        regRdata
);

    typedef enum { ST_FETCH, ST_SRC, ST_DST, ST_EXEC, ST_WRITE } state_t;

    state_t        state;
    instr_t        ir;
    logic [7:0]    regs [REG_COUNT];
    logic [7:0]    leftSel;
    logic [7:0]    rightSel;
    logic [7:0]    srcByte;
    logic [7:0]    dstByte;
    logic [AW-1:0] pc;
    logic          carry;
    logic          inIndirect;
    logic          run;
    logic [7:0]    divCnt;
    logic          tick;

    // Phase divider
    always_ff @(posedge clk) begin
        if (!nrst) begin
            divCnt <= 8'h00;
            tick   <= 1'b0;
        end else if (divCnt == 8'(PHASE_CYCLES - 1)) begin
            divCnt <= 8'h00;
            tick   <= 1'b1;
        end else begin
            divCnt <= divCnt + 8'h01;
            tick   <= 1'b0;
        end
    end

    // Decode
    logic [2:0] op;
    logic [4:0] tgt;
    logic       isAlu;
    logic       srcIv;
    logic       tgtIv;
    logic       regForm;
    logic       writes;
    logic [3:0] fieldLen;
    logic [7:0] lenMask;
    logic [7:0] imm;
    logic [2:0] srcShift;
    logic [2:0] tgtShift;

    always_comb begin
        op       = ir.op;
        isAlu    = (op <= OP_XOR);
        tgt      = (op == OP_LITERAL_TRANSMIT) ? ir.src : ir.dst;
        srcIv    = ir.src[4];
        tgtIv    = tgt[4];
        regForm  = !ir.src[4];
        writes   = isAlu || (op == OP_LITERAL_TRANSMIT);
        fieldLen = (ir.rl == RL_FULL_BYTE) ? LEN_FULL
                                           : {1'b0, ir.rl};
        lenMask  = (fieldLen >= LEN_FULL) ? 8'hff
                 : 8'((9'h001 << fieldLen) - 9'h001);
        imm      = regForm ? {ir.rl, ir.dst}
                           : {3'h0, ir.dst};
        srcShift = ~ir.src[2:0];
        tgtShift = ~tgt[2:0];
    end

    // Operand fetch
    logic [7:0] regVal;
    logic [7:0] srcData;
    logic [8:0] sum9;
    logic [7:0] result;
    logic [7:0] fieldMask;
    logic [7:0] merged;
    logic [7:0] indirectSum;
    logic       branchTaken;

    always_comb begin
        if (ir.src <= SEL_LAST_WORKING || ir.src == SEL_R11) begin
            regVal = regs[ir.src[3:0]];
        end else if (ir.src == SEL_CARRY_FLAG) begin
            regVal = {7'h00, carry};
        end else begin
            regVal = 8'h00;
        end
        if (srcIv) begin
            srcData = (srcByte >> srcShift) & lenMask;
        end else if (isAlu && !tgtIv) begin
            srcData = 8'({regVal, regVal} >> ir.rl);
        end else begin
            srcData = regVal;
        end
        sum9 = {1'b0, srcData} + {1'b0, regs[SEL_AUX[3:0]]};
        case (op)
            OP_MOVE:             result = srcData;
            OP_ADD:              result = sum9[7:0];
            OP_AND:              result = srcData & regs[0];
            OP_XOR:              result = srcData ^ regs[0];
            OP_LITERAL_TRANSMIT: result = imm;
            default:             result = srcData;
        endcase
        fieldMask = 8'(lenMask << tgtShift);
        merged    = (dstByte & ~fieldMask)
                  | (8'(result << tgtShift) & fieldMask);
        indirectSum = srcData + imm;
        branchTaken = (srcData != 8'h00);
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_FETCH;
        end else if (tick) begin
            case (state)
                ST_FETCH: state <= run ? ST_SRC : ST_FETCH;
                ST_SRC:   state <= ST_DST;
                ST_DST:   state <= ST_EXEC;
                ST_EXEC:  state <= ST_WRITE;
                ST_WRITE: state <= ST_FETCH;
                default:  state <= ST_FETCH;
            endcase
        end
    end

    // Instruction and port byte capture
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ir      <= '0;
            srcByte <= 8'h00;
            dstByte <= 8'h00;
        end else if (tick) begin
            if (state == ST_FETCH && run) begin
                ir <= instr_t'(instr);
            end
            if (state == ST_SRC) begin
                srcByte <= ivIn;
            end
            if (state == ST_DST) begin
                dstByte <= ivIn;
            end
        end
    end

    // Working registers and carry
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= 8'h00;
            end
            carry <= 1'b0;
        end else if (tick && state == ST_EXEC && writes) begin
            if (!tgtIv && (tgt <= SEL_LAST_WORKING || tgt == SEL_R11)) begin
                regs[tgt[3:0]] <= result;
            end
            if (op == OP_ADD) begin
                carry <= sum9[8];
            end
        end
    end

    // Bank selection
    always_ff @(posedge clk) begin
        if (!nrst) begin
            leftSel  <= 8'h00;
            rightSel <= 8'h00;
        end else if (tick && state == ST_EXEC && writes) begin
            if (tgt == SEL_LEFT_PORT_SELECT) begin
                leftSel <= result;
            end
            if (tgt == SEL_RIGHT_PORT_SELECT) begin
                rightSel <= result;
            end
        end
    end

    // Program counter and address
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pc       <= '0;
            progAddr <= '0;
            inIndirect <= 1'b0;
        end else if (tick && state == ST_EXEC) begin
            inIndirect <= (op == OP_EXECUTE_INDIRECT);
            case (op)
                OP_ABSOLUTE_JUMP: begin
                    pc       <= AW'({ir.src, ir.rl, ir.dst});
                    progAddr <= AW'({ir.src, ir.rl, ir.dst});
                end
                OP_EXECUTE_INDIRECT: begin
                    if (regForm) begin
                        progAddr <= {pc[AW-1:8], indirectSum};
                    end else begin
                        progAddr <= {pc[AW-1:SHORT_IMM_WIDTH],
                                     indirectSum[SHORT_IMM_WIDTH-1:0]};
                    end
                end
                OP_BRANCH_NONZERO: begin
                    if (branchTaken && regForm) begin
                        pc       <= {pc[AW-1:8], imm};
                        progAddr <= {pc[AW-1:8], imm};
                    end else if (branchTaken) begin
                        pc       <= {pc[AW-1:SHORT_IMM_WIDTH],
                                     imm[SHORT_IMM_WIDTH-1:0]};
                        progAddr <= {pc[AW-1:SHORT_IMM_WIDTH],
                                     imm[SHORT_IMM_WIDTH-1:0]};
                    end else begin
                        pc       <= pc + AW'(1);
                        progAddr <= pc + AW'(1);
                    end
                end
                default: begin
                    pc       <= pc + AW'(1);
                    progAddr <= pc + AW'(1);
                end
            endcase
        end
    end

    // Interface vector bus drive
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ivCtl <= IV_IDLE;
        end else if (tick) begin
            ivCtl <= IV_IDLE;
            case (state)
                ST_FETCH: begin
                    if (run && instr[12]
                        && instr[15:13] != OP_ABSOLUTE_JUMP
                        && instr[15:13] != OP_LITERAL_TRANSMIT) begin
                        // Read the source bank byte already selected
                        ivCtl.leftBankStrobe_n  <= instr[11];
                        ivCtl.rightBankStrobe_n <= !instr[11];
                    end
                end
                ST_SRC: begin
                    if (writes && tgtIv) begin
                        ivCtl.leftBankStrobe_n  <= tgt[3];
                        ivCtl.rightBankStrobe_n <= !tgt[3];
                    end
                end
                ST_EXEC: begin
                    if (writes && tgt == SEL_LEFT_PORT_SELECT) begin
                        ivCtl.leftBankStrobe_n    <= 1'b0;
                        ivCtl.selectCommandStrobe <= 1'b1;
                        ivCtl.drive_n             <= 1'b0;
                        ivCtl.data                <= result;
                    end else if (writes && tgt == SEL_RIGHT_PORT_SELECT) begin
                        ivCtl.rightBankStrobe_n   <= 1'b0;
                        ivCtl.selectCommandStrobe <= 1'b1;
                        ivCtl.drive_n             <= 1'b0;
                        ivCtl.data                <= result;
                    end else if (writes && tgtIv) begin
                        ivCtl.leftBankStrobe_n  <= tgt[3];
                        ivCtl.rightBankStrobe_n <= !tgt[3];
                        ivCtl.writeStrobe       <= 1'b1;
                        ivCtl.drive_n           <= 1'b0;
                        ivCtl.data              <= merged;
                    end
                end
                default: begin
                    ivCtl <= IV_IDLE;
                end
            endcase
        end
    end

    // Software register port
    always_ff @(posedge clk) begin
        if (!nrst) begin
            run      <= CTRL_RUN_RESET[0];
            regRdata <= 32'h0000_0000;
        end else begin
            if (regWr && regAddr == REG_CTRL) begin
                run <= regWdata[CTRL_RUN_BIT];
            end
            regRdata <= 32'h0000_0000;
            if (regRd && regAddr == REG_CTRL) begin
                regRdata[CTRL_RUN_BIT] <= run;
            end else if (regRd && regAddr == REG_STATUS) begin
                regRdata[AW-1:0]             <= pc;
                regRdata[STATUS_CARRY_BIT]   <= carry;
            end
        end
    end

    // Checks
    logic execTick;
    assign execTick = tick && state == ST_EXEC;

    property p_len_full;
        @(posedge clk) disable iff (!nrst)
        (ir.rl == RL_FULL_BYTE) |-> (lenMask == 8'hff && fieldLen == 4'h8);
    endproperty
    a_len_full: assert property (p_len_full)
        else $error("length code zero is not eight bits");

    property p_carry_add_only;
        @(posedge clk) disable iff (!nrst)
        $changed(carry) |-> $past(execTick && op == OP_ADD);
    endproperty
    a_carry_add_only: assert property (p_carry_add_only)
        else $error("carry changed outside add");

    property p_carry_value;
        @(posedge clk) disable iff (!nrst)
        (execTick && op == OP_ADD) |=> carry == $past(sum9[8]);
    endproperty
    a_carry_value: assert property (p_carry_value)
        else $error("carry does not match sum carry out");

    property p_jump;
        @(posedge clk) disable iff (!nrst)
        (execTick && op == OP_ABSOLUTE_JUMP)
            |=> pc == $past(ir[12:0]) && progAddr == pc;
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump target not taken from address field");

    property p_indirect_keeps_pc;
        @(posedge clk) disable iff (!nrst)
        (execTick && op == OP_EXECUTE_INDIRECT) |=> $stable(pc);
    endproperty
    a_indirect_keeps_pc: assert property (p_indirect_keeps_pc)
        else $error("execute changed the program counter");

    property p_after_indirect;
        @(posedge clk) disable iff (!nrst)
        (execTick && inIndirect && op <= OP_LITERAL_TRANSMIT
            && op != OP_BRANCH_NONZERO && op != OP_EXECUTE_INDIRECT)
            |=> pc == $past(pc) + AW'(1) && progAddr == pc;
    endproperty
    a_after_indirect: assert property (p_after_indirect)
        else $error("indirect instruction moved the counter");

    property p_select_strobe;
        @(posedge clk) disable iff (!nrst)
        ivCtl.selectCommandStrobe |-> !ivCtl.drive_n
            && (ivCtl.leftBankStrobe_n != ivCtl.rightBankStrobe_n);
    endproperty
    a_select_strobe: assert property (p_select_strobe)
        else $error("select strobe without one bank and bus drive");

    property p_left_hold;
        @(posedge clk) disable iff (!nrst)
        !(execTick && writes && tgt == SEL_LEFT_PORT_SELECT)
            |=> $stable(leftSel);
    endproperty
    a_left_hold: assert property (p_left_hold)
        else $error("left selection changed without a write");

    property p_merge_keeps;
        @(posedge clk) disable iff (!nrst)
        (execTick && writes && tgtIv)
            |=> ivCtl.writeStrobe
            && (ivCtl.data & ~$past(fieldMask))
               == ($past(dstByte) & ~$past(fieldMask));
    endproperty
    a_merge_keeps: assert property (p_merge_keeps)
        else $error("bits outside the field were altered");

    property p_sel_reads_zero;
        @(posedge clk) disable iff (!nrst)
        (state == ST_EXEC && (ir.src == SEL_LEFT_PORT_SELECT
            || ir.src == SEL_RIGHT_PORT_SELECT)) |-> regVal == 8'h00;
    endproperty
    a_sel_reads_zero: assert property (p_sel_reads_zero)
        else $error("select register read back non-zero");

endmodule : operand_decode

// ==== verif/iv_model.sv ====
// Behavioural port bytes on the left and right banks.
// Assumes the core's ivCtl carrier and a single clock.
`timescale 1ns/1ns
module iv_model
    import ctl_pkg::*;
(
    // Clock
    input  wire logic   clk,
    // Interface vector bus
    input  wire ivCtl_t ivCtl,
    output logic [7:0]  ivIn
);
    logic [7:0] memL [256];
    logic [7:0] memR [256];
    logic [7:0] selL;
    logic [7:0] selR;
    logic [7:0] lastOut;

    initial begin
        for (int i = 0; i < 256; i++) begin
            memL[i] = i[7:0];
            memR[i] = i[7:0];
        end
        selL = 8'h00;
        selR = 8'h00;
        lastOut = 8'h00;
    end

    // Selection held until its bank is selected again
    always @(posedge clk) begin
        if (ivCtl.selectCommandStrobe && !ivCtl.leftBankStrobe_n) begin
            selL <= ivCtl.data;
        end
        if (ivCtl.selectCommandStrobe && !ivCtl.rightBankStrobe_n) begin
            selR <= ivCtl.data;
        end
        if (ivCtl.writeStrobe && !ivCtl.leftBankStrobe_n) begin
            memL[selL] <= ivCtl.data;
        end
        if (ivCtl.writeStrobe && !ivCtl.rightBankStrobe_n) begin
            memR[selR] <= ivCtl.data;
        end
        lastOut <= ivIn;
    end

    // Read path; a released bus shows a changing value
    always_comb begin
        if (ivCtl.selectCommandStrobe || ivCtl.writeStrobe) begin
            ivIn = ~lastOut;
        end else if (!ivCtl.leftBankStrobe_n) begin
            ivIn = memL[selL];
        end else if (!ivCtl.rightBankStrobe_n) begin
            ivIn = memR[selR];
        end else begin
            ivIn = ~lastOut;
        end
    end
endmodule : iv_model

// ==== verif/tb_operand_decode.sv ====
// Testbench: runs a short program and checks port bytes and status.
// Assumes the core, iv_model and a 50 MHz clock.
`timescale 1ns/1ns
module tb_operand_decode
    import ctl_pkg::*;
;
    localparam logic [15:0] CODE [24] = '{
        16'hc081, 16'hc190, 16'hc703, 16'hcfff, 16'h2102, 16'h0183,
        16'h0317, 16'h027d, 16'h5784, 16'h7785, 16'hcf04, 16'h041f,
        16'hcf05, 16'h051f, 16'hcf06, 16'h171f, 16'hcf07, 16'h081f,
        16'hcf08, 16'h071f, 16'h80bf, 16'hcf09, 16'h061f, 16'ha630};

    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [12:0] progAddr;
    logic [15:0] instr;
    ivCtl_t      ivCtl;
    logic [7:0]  ivIn;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdata;
    logic [31:0] rd;
    logic [15:0] prog [8192];
    int          errCount = 0;
    int          testsRun = 0;

    always #10 clk = ~clk;
    assign instr = prog[progAddr];

    operand_decode #(.AW(PROG_ADDR_WIDTH)) i_operand_decode (
        .clk(clk), .nrst(nrst), .progAddr(progAddr), .instr(instr),
        .ivCtl(ivCtl), .ivIn(ivIn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata));

    iv_model i_iv_model (.clk(clk), .ivCtl(ivCtl), .ivIn(ivIn));

    task automatic endSim();
        if (errCount == 0 && testsRun > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : endSim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkB(input logic [7:0] got, input logic [7:0] exp);
        chk({24'h0, got}, {24'h0, exp});
    endtask : chkB

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask : regRead

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        errCount++;
        endSim();
    end

    initial begin
        for (int i = 0; i < 8192; i++) begin
            prog[i] = 16'h0000;
        end
        for (int i = 0; i < 24; i++) begin
            prog[i] = CODE[i];
        end
        prog[13'h0030] = 16'hcf0b;
        prog[13'h0031] = 16'hdff5;
        prog[13'h0032] = 16'ha900;
        prog[13'h0033] = 16'hbfb8;
        prog[13'h0038] = 16'hff00;
        prog[13'h0040] = 16'hc65a;
        prog[13'h1f00] = 16'hff00;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        regRead(REG_STATUS, rd);
        chk(rd, 32'h0);
        regRead(REG_CTRL, rd);
        chk(rd, 32'h0);
        regRead(8'h10, rd);
        chk(rd, 32'h0);
        regWrite(8'h10, 32'h1);
        repeat (30) @(posedge clk);
        regRead(REG_STATUS, rd);
        chk(rd, 32'h0);
        regWrite(REG_CTRL, 32'h1);
        for (int i = 0; i < 300 && rd[12:0] !== 13'h1f00; i++) begin
            regRead(REG_STATUS, rd);
        end
        chk(rd, 32'h3f00);
        chkB(i_iv_model.selL, 8'h03);
        chkB(i_iv_model.memL[3], 8'h09);
        chkB(i_iv_model.memR[255], 8'he7);
        chkB(i_iv_model.memR[4], 8'h01);
        chkB(i_iv_model.memR[5], 8'h88);
        chkB(i_iv_model.memR[6], 8'h09);
        chkB(i_iv_model.memR[7], 8'h01);
        chkB(i_iv_model.memR[8], 8'h00);
        chkB(i_iv_model.memR[9], 8'h5a);
        chkB(i_iv_model.memR[10], 8'h0a);
        chkB(i_iv_model.memR[11], 8'h15);
        endSim();
    end
endmodule : tb_operand_decode
